// [apg_pkg.sv]
// Purpose: constants, register map and types of the axis pulse profile generator
// Assumes: 200 MHz clock, AHB-Lite word registers
// Notes: speed is a phase increment per clock; one pulse per phase wrap
`default_nettype none
package apg_pkg;
	localparam int AXN = 4;
	localparam int INN = 4;
	localparam int CW = 24;
	localparam int SW = 16;
	localparam int PW = 24;
	// register byte offsets
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_MODE1 = 8'h04;
	localparam logic [7:0] A_MODE2 = 8'h08;
	localparam logic [7:0] A_PROF = 8'h0C;
	localparam logic [7:0] A_OUT = 8'h10;
	localparam logic [7:0] A_INTP = 8'h14;
	localparam logic [7:0] A_DATA = 8'h18;
	localparam logic [7:0] A_AXSEL = 8'h1C;
	localparam logic [7:0] A_INIT = 8'h20;
	localparam logic [7:0] A_DRV = 8'h24;
	localparam logic [7:0] A_ACC = 8'h28;
	localparam logic [7:0] A_PCNT = 8'h2C;
	localparam logic [7:0] A_OFS = 8'h30;
	localparam logic [7:0] A_MDP = 8'h34;
	localparam logic [7:0] A_DEC = 8'h38;
	localparam logic [7:0] A_ST_RUN = 8'h40;
	localparam logic [7:0] A_ST_AX = 8'h44;
	localparam logic [7:0] A_ST_CNT = 8'h48;
	localparam logic [7:0] A_ST_SPD = 8'h4C;
	localparam logic [7:0] A_ST_IN = 8'h50;
	// command codes
	localparam logic [7:0] C_SET_DEC = 8'h03;
	localparam logic [7:0] C_FIX_P = 8'h20;
	localparam logic [7:0] C_FIX_N = 8'h21;
	localparam logic [7:0] C_CON_P = 8'h22;
	localparam logic [7:0] C_CON_N = 8'h23;
	localparam logic [7:0] C_DSTOP = 8'h26;
	localparam logic [7:0] C_SSTOP = 8'h27;
	// field positions
	localparam int F_CODE = 8;
	localparam int F_RSEL = 4;
	localparam int M1_EN = 0;
	localparam int M1_LVL = 4;
	localparam int M1_SUD = 8;
	localparam int M2_SWSEL = 0;
	localparam int M2_FMT = 1;
	localparam int M2_INV = 2;
	localparam int P_MAN = 0;
	localparam int P_SEP = 1;
	localparam int P_SCUR = 2;
	// reset values
	localparam logic [CW-1:0] OFS_RST = 24'h000008;
	localparam logic [SW-1:0] AC_START = 16'h0001;
	// speed update tick
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
	typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_RUN, ST_DEC} apg_state_e;
endpackage : apg_pkg
`default_nettype wire

// [apg_axis_pulse_profile_generator.sv]
// Purpose: four-axis pulse profile generator with AHB-Lite register slave
// Assumes: single word transfers; hready_in is this slave's hreadyout
// Notes: reads take one wait state, writes none
// Summary of operation
// R01: each of four axes runs trapezoid or S-curve ramps, shared or separate rates.
// R02: writable command, three mode, output and interpolation mode registers; readable status.
// R03: every axis drives either a preset pulse count or endlessly.
// R04: pulse signalling format chosen by a jumper pin or a register bit.
// R05: host loads all parameters first; the axis then runs alone.
// R06: fixed drive stops once emitted pulses equal the commanded count.
// R07: a larger count written during driving extends the motion.
// R08: a count below pulses already emitted stops output at once.
// R09: count change in S-curve may end with a truncated deceleration.
// R10: S-curve decel starts when remaining pulses reach pulses spent accelerating.
// R11: offset starts decel earlier; leftover offset pulses go at initial speed.
// R12: deceleration offset resets to eight.
// R13: continuous drive runs until stop command or external stop input.
// R14: two stop commands: decelerating stop and sudden stop.
// R15: four external stop inputs per axis with enable, level and mode.
// R16: drive speed not above initial speed means constant speed, no ramps.
// R17: host should use low constant speed where sensor sudden stops are needed.
// R18: trapezoid ramps up counting pulses, ramps down when remaining below that.
// R19: separate-decel select uses its own deceleration rate.
// R20: separate decel in fixed drive needs a manual decel point.
// R21: host sets separate-decel select, then issues decel setting command.
// R22: decel stop ramps to initial speed then stops; sudden stop drops next pulse.
`timescale 1ns/100ps
`default_nettype none
module apg_axis_pulse_profile_generator (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic [15:0] ext_stop_in,
	input wire logic fmt_jumper_in,
	output logic [3:0] pulse_a_out,
	output logic [3:0] pulse_b_out,
	output logic [7:0] gp_out
);
	localparam int CW = apg_pkg::CW;
	localparam int SW = apg_pkg::SW;
	localparam int PW = apg_pkg::PW;
	localparam int AXN = apg_pkg::AXN;

	function automatic logic [1:0] ext_act(input logic [11:0] m, input logic [3:0] pin);
		logic [3:0] act;
		act = m[apg_pkg::M1_EN +: 4] & ~(pin ^ m[apg_pkg::M1_LVL +: 4]);
		ext_act = {|(act & m[apg_pkg::M1_SUD +: 4]), |(act & ~m[apg_pkg::M1_SUD +: 4])};
	endfunction : ext_act

	// bus state and registers
	logic dp_wr_reg, dp_wr_next, dp_rd_reg, dp_rd_next, rdy_reg, rdy_next;
	logic [7:0] dp_addr_reg, dp_addr_next;
	logic [31:0] rd_reg, rd_next, cmd_reg, cmd_next, data_reg, data_next;
	logic [3:0] m2_reg, m2_next;
	logic [7:0] out_reg, out_next;
	logic [15:0] intp_reg, intp_next;
	logic [5:0] axsel_reg, axsel_next;
	logic [11:0] m1_reg [AXN];
	logic [11:0] m1_next [AXN];
	logic [2:0] pm_reg [AXN];
	logic [2:0] pm_next [AXN];
	logic [SW-1:0] init_reg [AXN];
	logic [SW-1:0] init_next [AXN];
	logic [SW-1:0] drv_reg [AXN];
	logic [SW-1:0] drv_next [AXN];
	logic [SW-1:0] acc_reg [AXN];
	logic [SW-1:0] acc_next [AXN];
	logic [SW-1:0] dec_reg [AXN];
	logic [SW-1:0] dec_next [AXN];
	logic [CW-1:0] pcnt_reg [AXN];
	logic [CW-1:0] pcnt_next [AXN];
	logic [CW-1:0] ofs_reg [AXN];
	logic [CW-1:0] ofs_next [AXN];
	logic [CW-1:0] mdp_reg [AXN];
	logic [CW-1:0] mdp_next [AXN];
	// tick divider, synchronisers, pulse outputs
	logic [11:0] div_reg, div_next;
	logic tick_reg, tick_next;
	logic [16:0] s1_reg, s1_next, s2_reg, s2_next;
	logic [3:0] pa_reg, pa_next, pb_reg, pb_next;
	// per-axis views
	wire logic run_w [AXN];
	wire logic msb_w [AXN];
	wire logic dir_w [AXN];
	wire logic [CW-1:0] cnt_w [AXN];
	wire logic [SW-1:0] spd_w [AXN];
	wire logic [4:0] stat_w [AXN];
	wire logic cmd_v;
	wire logic [7:0] cmd_code;
	wire logic [3:0] cmd_mask;
	wire logic [1:0] rs;

	assign cmd_v = dp_wr_reg && (dp_addr_reg == apg_pkg::A_CMD);
	assign cmd_code = hwdata_in[apg_pkg::F_CODE +: 8];
	assign cmd_mask = hwdata_in[3:0];
	assign rs = axsel_reg[apg_pkg::F_RSEL +: 2];

	always_comb
	begin
		dp_wr_next = 1'b0;
		dp_rd_next = dp_rd_reg;
		dp_addr_next = dp_addr_reg;
		rdy_next = rdy_reg;
		rd_next = rd_reg;
		cmd_next = cmd_reg;
		data_next = data_reg;
		m2_next = m2_reg;
		out_next = out_reg;
		intp_next = intp_reg;
		axsel_next = axsel_reg;
		m1_next = m1_reg;
		pm_next = pm_reg;
		init_next = init_reg;
		drv_next = drv_reg;
		acc_next = acc_reg;
		dec_next = dec_reg;
		pcnt_next = pcnt_reg;
		ofs_next = ofs_reg;
		mdp_next = mdp_reg;
		if (dp_rd_reg && !rdy_reg)
		begin
			rdy_next = 1'b1;
			dp_rd_next = 1'b0;
			rd_next = 32'h00000000;
			case (dp_addr_reg)
				apg_pkg::A_CMD: rd_next = cmd_reg;
				apg_pkg::A_MODE1: rd_next[11:0] = m1_reg[rs];
				apg_pkg::A_MODE2: rd_next[3:0] = m2_reg;
				apg_pkg::A_PROF: rd_next[2:0] = pm_reg[rs];
				apg_pkg::A_OUT: rd_next[7:0] = out_reg;
				apg_pkg::A_INTP: rd_next[15:0] = intp_reg;
				apg_pkg::A_DATA: rd_next = data_reg;
				apg_pkg::A_AXSEL: rd_next[5:0] = axsel_reg;
				apg_pkg::A_INIT: rd_next[SW-1:0] = init_reg[rs];
				apg_pkg::A_DRV: rd_next[SW-1:0] = drv_reg[rs];
				apg_pkg::A_ACC: rd_next[SW-1:0] = acc_reg[rs];
				apg_pkg::A_DEC: rd_next[SW-1:0] = dec_reg[rs];
				apg_pkg::A_PCNT: rd_next[CW-1:0] = pcnt_reg[rs];
				apg_pkg::A_OFS: rd_next[CW-1:0] = ofs_reg[rs];
				apg_pkg::A_MDP: rd_next[CW-1:0] = mdp_reg[rs];
				apg_pkg::A_ST_RUN: rd_next[3:0] = {run_w[3], run_w[2], run_w[1], run_w[0]};
				apg_pkg::A_ST_AX: rd_next[4:0] = stat_w[rs];
				apg_pkg::A_ST_CNT: rd_next[CW-1:0] = cnt_w[rs];
				apg_pkg::A_ST_SPD: rd_next[SW-1:0] = spd_w[rs];
				apg_pkg::A_ST_IN: rd_next[16:0] = s2_reg;
				default: rd_next = 32'h00000000;
			endcase
		end
		if (hsel_in && htrans_in[1] && hready_in)
		begin
			dp_addr_next = haddr_in[7:0];
			dp_wr_next = hwrite_in;
			dp_rd_next = !hwrite_in;
			rdy_next = hwrite_in;
		end
		if (dp_wr_reg)
		begin
			case (dp_addr_reg)
				apg_pkg::A_CMD: cmd_next = hwdata_in; // R02
				apg_pkg::A_MODE2: m2_next = hwdata_in[3:0];
				apg_pkg::A_OUT: out_next = hwdata_in[7:0];
				apg_pkg::A_INTP: intp_next = hwdata_in[15:0];
				apg_pkg::A_DATA: data_next = hwdata_in;
				apg_pkg::A_AXSEL: axsel_next = hwdata_in[5:0];
				default: ;
			endcase
		end
		for (int a = 0; a < AXN; a++)
		begin
			if (dp_wr_reg && axsel_reg[a])
			begin
				case (dp_addr_reg)
					apg_pkg::A_MODE1: m1_next[a] = hwdata_in[11:0];
					apg_pkg::A_PROF: pm_next[a] = hwdata_in[2:0];
					apg_pkg::A_INIT: init_next[a] = hwdata_in[SW-1:0];
					apg_pkg::A_DRV: drv_next[a] = hwdata_in[SW-1:0];
					apg_pkg::A_ACC: acc_next[a] = hwdata_in[SW-1:0];
					apg_pkg::A_PCNT: pcnt_next[a] = hwdata_in[CW-1:0]; // R05
					apg_pkg::A_OFS: ofs_next[a] = hwdata_in[CW-1:0];
					apg_pkg::A_MDP: mdp_next[a] = hwdata_in[CW-1:0];
					default: ;
				endcase
			end
			if (cmd_v && cmd_mask[a] && cmd_code == apg_pkg::C_SET_DEC)
				dec_next[a] = data_reg[SW-1:0]; // R21
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			dp_wr_reg <= 1'b0;
			dp_rd_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			rdy_reg <= 1'b1;
			rd_reg <= 32'h00000000;
			cmd_reg <= 32'h00000000;
			data_reg <= 32'h00000000;
			m2_reg <= 4'h0;
			out_reg <= 8'h00;
			intp_reg <= 16'h0000;
			axsel_reg <= 6'h00;
			for (int a = 0; a < AXN; a++)
			begin
				m1_reg[a] <= 12'h000;
				pm_reg[a] <= 3'h0;
				init_reg[a] <= 16'h0000;
				drv_reg[a] <= 16'h0000;
				acc_reg[a] <= 16'h0000;
				dec_reg[a] <= 16'h0000;
				pcnt_reg[a] <= 24'h000000;
				ofs_reg[a] <= apg_pkg::OFS_RST; // R12
				mdp_reg[a] <= 24'h000000;
			end
		end
		else
		begin
			dp_wr_reg <= dp_wr_next;
			dp_rd_reg <= dp_rd_next;
			dp_addr_reg <= dp_addr_next;
			rdy_reg <= rdy_next;
			rd_reg <= rd_next;
			cmd_reg <= cmd_next;
			data_reg <= data_next;
			m2_reg <= m2_next;
			out_reg <= out_next;
			intp_reg <= intp_next;
			axsel_reg <= axsel_next;
			m1_reg <= m1_next;
			pm_reg <= pm_next;
			init_reg <= init_next;
			drv_reg <= drv_next;
			acc_reg <= acc_next;
			dec_reg <= dec_next;
			pcnt_reg <= pcnt_next;
			ofs_reg <= ofs_next;
			mdp_reg <= mdp_next;
		end
	end

	// speed tick, input synchronisers and pulse formatting
	always_comb
	begin
		tick_next = (div_reg == apg_pkg::TICK_LAST);
		div_next = tick_next ? 12'h000 : div_reg + 12'h001;
		s1_next = {fmt_jumper_in, ext_stop_in};
		s2_next = s1_reg;
		for (int a = 0; a < AXN; a++)
		begin
			logic p, cw, inv;
			p = run_w[a] & msb_w[a];
			cw = m2_reg[apg_pkg::M2_SWSEL] ? m2_reg[apg_pkg::M2_FMT] : s2_reg[16]; // R04
			inv = m2_reg[apg_pkg::M2_INV];
			pa_next[a] = (cw ? (p & ~dir_w[a]) : p) ^ inv;
			pb_next[a] = cw ? ((p & dir_w[a]) ^ inv) : dir_w[a];
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			div_reg <= 12'h000;
			tick_reg <= 1'b0;
			s1_reg <= 17'h00000;
			s2_reg <= 17'h00000;
			pa_reg <= 4'h0;
			pb_reg <= 4'h0;
		end
		else
		begin
			div_reg <= div_next;
			tick_reg <= tick_next;
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			pa_reg <= pa_next;
			pb_reg <= pb_next;
		end
	end

	for (genvar i = 0; i < AXN; i++)
	begin : g_ax
		apg_pkg::apg_state_e st_reg, st_next;
		logic [CW-1:0] cnt_reg, cnt_next, apc_reg, apc_next, rem;
		logic [PW-1:0] ph_reg, ph_next;
		logic [SW-1:0] spd_reg, spd_next, ac_reg, ac_next, rate, step;
		logic dir_reg, dir_next, con_reg, con_next, stp_reg, stp_next;
		logic [PW:0] sum;
		logic [CW:0] thr;
		logic [SW:0] up;
		logic [1:0] ex;
		logic hit, cst, sep, dtrig;

		assign run_w[i] = (st_reg != apg_pkg::ST_IDLE);
		assign msb_w[i] = ph_reg[PW-1];
		assign dir_w[i] = dir_reg;
		assign cnt_w[i] = cnt_reg;
		assign spd_w[i] = spd_reg;
		assign stat_w[i] = {stp_reg, con_reg, dir_reg, st_reg};

		always_comb
		begin
			st_next = st_reg;
			cnt_next = cnt_reg;
			apc_next = apc_reg;
			ph_next = ph_reg;
			spd_next = spd_reg;
			ac_next = ac_reg;
			dir_next = dir_reg;
			con_next = con_reg;
			stp_next = stp_reg;
			hit = cmd_v && cmd_mask[i];
			ex = ext_act(m1_reg[i], s2_reg[4*i +: 4]); // R15
			cst = (drv_reg[i] <= init_reg[i]);
			sep = pm_reg[i][apg_pkg::P_SEP];
			rem = pcnt_reg[i] - cnt_reg;
			thr = {1'b0, apc_reg} + {1'b0, ofs_reg[i]};
			rate = (st_reg == apg_pkg::ST_DEC && sep) ? dec_reg[i] : acc_reg[i]; // R19
			step = pm_reg[i][apg_pkg::P_SCUR] ? ac_reg : rate; // R01
			sum = {1'b0, ph_reg} + {{(PW + 1 - SW){1'b0}}, spd_reg};
			up = {1'b0, spd_reg} + {1'b0, step};
			dtrig = 1'b0;
			if (st_reg == apg_pkg::ST_IDLE)
			begin
				if (hit && cmd_code >= apg_pkg::C_FIX_P && cmd_code <= apg_pkg::C_CON_N)
				begin
					st_next = cst ? apg_pkg::ST_RUN : apg_pkg::ST_ACC; // R16
					con_next = (cmd_code >= apg_pkg::C_CON_P); // R03
					dir_next = cmd_code[0];
					spd_next = init_reg[i];
					ph_next = '0;
					cnt_next = '0;
					apc_next = '0;
					stp_next = 1'b0;
					ac_next = apg_pkg::AC_START;
				end
			end
			else
			begin
				ph_next = sum[PW-1:0];
				if (sum[PW])
				begin
					cnt_next = cnt_reg + 24'h000001;
					if (st_reg == apg_pkg::ST_ACC)
						apc_next = apc_reg + 24'h000001; // R10 R18
				end
				if ((hit && cmd_code == apg_pkg::C_DSTOP) || ex[0])
					stp_next = 1'b1; // R13 R14
				if ((hit && cmd_code == apg_pkg::C_SSTOP) || ex[1])
					st_next = apg_pkg::ST_IDLE; // R14 R22
				else if (!con_reg && cnt_reg >= pcnt_reg[i])
					st_next = apg_pkg::ST_IDLE; // R06 R08
				else if (cst)
				begin
					if (stp_next)
						st_next = apg_pkg::ST_IDLE; // R16
				end
				else
				begin
					if (stp_next)
						dtrig = 1'b1;
					else if (!con_reg && (pm_reg[i][apg_pkg::P_MAN] || sep))
						dtrig = (rem <= mdp_reg[i]); // R20
					else if (!con_reg)
						dtrig = ({1'b0, rem} <= thr); // R10 R11 R18
					if (tick_reg && pm_reg[i][apg_pkg::P_SCUR] && ac_reg < rate)
						ac_next = ac_reg + 16'h0001;
					case (st_reg)
						apg_pkg::ST_ACC, apg_pkg::ST_RUN:
						begin
							if (dtrig)
							begin
								st_next = apg_pkg::ST_DEC;
								ac_next = apg_pkg::AC_START;
							end
							else if (st_reg == apg_pkg::ST_ACC && tick_reg)
							begin
								if (up >= {1'b0, drv_reg[i]})
								begin
									spd_next = drv_reg[i];
									st_next = apg_pkg::ST_RUN;
								end
								else
									spd_next = up[SW-1:0]; // R18
							end
						end
						apg_pkg::ST_DEC:
						begin
							if (!dtrig)
							begin
								st_next = apg_pkg::ST_ACC; // R07
								ac_next = apg_pkg::AC_START;
							end
							else if (tick_reg)
							begin
								if ({1'b0, spd_reg} <= {1'b0, init_reg[i]} + {1'b0, step})
								begin
									spd_next = init_reg[i]; // R11
									if (stp_reg || con_reg)
										st_next = apg_pkg::ST_IDLE; // R22
								end
								else
									spd_next = spd_reg - step; // R09
							end
						end
						default: st_next = apg_pkg::ST_IDLE;
					endcase
				end
			end
		end

		always_ff @(posedge clock_in or negedge rstn_in)
		begin
			if (!rstn_in)
			begin
				st_reg <= apg_pkg::ST_IDLE;
				cnt_reg <= '0;
				apc_reg <= '0;
				ph_reg <= '0;
				spd_reg <= '0;
				ac_reg <= '0;
				dir_reg <= 1'b0;
				con_reg <= 1'b0;
				stp_reg <= 1'b0;
			end
			else
			begin
				st_reg <= st_next;
				cnt_reg <= cnt_next;
				apc_reg <= apc_next;
				ph_reg <= ph_next;
				spd_reg <= spd_next;
				ac_reg <= ac_next;
				dir_reg <= dir_next;
				con_reg <= con_next;
				stp_reg <= stp_next;
			end
		end
	end

	assign hrdata_out = rd_reg;
	assign hreadyout_out = rdy_reg;
	assign hresp_out = 1'b0;
	assign pulse_a_out = pa_reg;
	assign pulse_b_out = pb_reg;
	assign gp_out = out_reg;
endmodule : apg_axis_pulse_profile_generator
`default_nettype wire

// [apg_checker.sv]
// Purpose: bus timing checks of the pulse profile generator
// Assumes: hready_in is tied to hreadyout_out
// Notes: sees the top module's ports only
`timescale 1ns/100ps
`default_nettype none
module apg_checker (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic [7:0] gp_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	logic req;
	logic wr_out;
	assign req = hsel_in & htrans_in[1] & hready_in;
	assign wr_out = req & hwrite_in & (haddr_in[7:0] == apg_pkg::A_OUT);
	property p_okay;
		hresp_out == 1'b0;
	endproperty
	property p_rd_wait;
		req & !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
	endproperty
	property p_wr_nowait;
		req & hwrite_in |=> hreadyout_out;
	endproperty
	property p_one_wait;
		!hreadyout_out |=> hreadyout_out;
	endproperty
	property p_wait_cause;
		$fell(hreadyout_out) |-> $past(req & !hwrite_in);
	endproperty
	property p_rd_hold;
		$changed(hrdata_out) |-> hreadyout_out & !$past(hreadyout_out);
	endproperty
	property p_gp_cause;
		$changed(gp_out) |-> $past(wr_out, 2);
	endproperty
	property p_gp_val;
		wr_out ##1 1'b1 |=> gp_out == $past(hwdata_in[7:0]);
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	a_one_wait: assert property (p_one_wait) else $error("wait too long");
	a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_gp_cause: assert property (p_gp_cause) else $error("outputs moved");
	a_gp_val: assert property (p_gp_val) else $error("outputs wrong");
	c_rd: cover property (req & !hwrite_in ##2 hreadyout_out);
	c_gp: cover property ($changed(gp_out));
	c_rdata: cover property ($changed(hrdata_out));
endmodule : apg_checker
bind apg_axis_pulse_profile_generator apg_checker u_chk (
	.clock_in(clock_in),
	.rstn_in(rstn_in),
	.hsel_in(hsel_in),
	.haddr_in(haddr_in),
	.htrans_in(htrans_in),
	.hwrite_in(hwrite_in),
	.hwdata_in(hwdata_in),
	.hready_in(hready_in),
	.hrdata_out(hrdata_out),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out),
	.gp_out(gp_out)
);
`default_nettype wire

// [apg_motor_model.sv]
// Purpose: motor drivers and stop sensors beside the generator
// Assumes: sensor lines pulled low when idle
// Notes: counts rising edges of both pulse lines per axis
`timescale 1ns/100ps
`default_nettype none
module apg_motor_model (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [3:0] pulse_a_in,
	input wire logic [3:0] pulse_b_in,
	input wire logic [3:0] stop_req_in,
	input wire logic clr_in,
	output logic [15:0] ext_stop_out,
	output logic [3:0][15:0] cnt_a_out,
	output logic [3:0][15:0] cnt_b_out
);
	logic [3:0] pa_q;
	logic [3:0] pb_q;
	always_comb
	begin
		ext_stop_out = 16'h0000;
		for (int a = 0; a < 4; a++)
			ext_stop_out[4 * a] = stop_req_in[a];
	end
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pa_q <= 4'h0;
			pb_q <= 4'h0;
			cnt_a_out <= '0;
			cnt_b_out <= '0;
		end
		else
		begin
			pa_q <= pulse_a_in;
			pb_q <= pulse_b_in;
			for (int a = 0; a < 4; a++)
			begin
				cnt_a_out[a] <= clr_in ? 16'h0000 : cnt_a_out[a] + 16'(pulse_a_in[a] & !pa_q[a]);
				cnt_b_out[a] <= clr_in ? 16'h0000 : cnt_b_out[a] + 16'(pulse_b_in[a] & !pb_q[a]);
			end
		end
	end
endmodule : apg_motor_model
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench of the pulse profile generator
// Assumes: pulse/dir format unless stated
// Notes: fixed seed random axis, counts and data
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clock_in, rstn_in, hsel, hwrite, jumper, clr, hready, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] ext_stop;
	logic [3:0] pa, pb, stop_req;
	logic [7:0] gp;
	logic [3:0][15:0] cnt_a, cnt_b;
	int num_errors, check_count, seed, ax, pc, k;
	apg_axis_pulse_profile_generator u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.ext_stop_in(ext_stop), .fmt_jumper_in(jumper), .pulse_a_out(pa), .pulse_b_out(pb), .gp_out(gp));
	apg_motor_model u_mot (.clock_in(clock_in), .rstn_in(rstn_in), .pulse_a_in(pa), .pulse_b_in(pb),
		.stop_req_in(stop_req), .clr_in(clr), .ext_stop_out(ext_stop), .cnt_a_out(cnt_a), .cnt_b_out(cnt_b));
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] stop_at(input logic [31:0] done, input logic [31:0] want);
		return (want < done) ? done : want;
	endfunction : stop_at
	task automatic rdy;
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1)
		begin
			@(negedge clock_in);
			r = hready;
			rd = hrdata;
			@(posedge clock_in);
			n++;
			if (n > 40)
			begin
				chk("bus ready", 32'h1, 32'h0);
				end_sim();
			end
		end
	endtask : rdy
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		haddr <= {24'h000000, a};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		rdy();
	endtask : rdr
	task automatic cmd(input logic [7:0] c, input int a);
		wr(apg_pkg::A_CMD, {16'h0000, c, 4'h0, 4'(1 << a)});
	endtask : cmd
	task automatic setup(input int a, input logic [31:0] sv, input logic [31:0] dv, input logic [31:0] n);
		wr(apg_pkg::A_AXSEL, 32'(a << 4 | 1 << a));
		wr(apg_pkg::A_INIT, sv);
		wr(apg_pkg::A_DRV, dv);
		wr(apg_pkg::A_ACC, 32'h00002000);
		wr(apg_pkg::A_PCNT, n);
		clr <= 1'b1;
		@(posedge clock_in);
		clr <= 1'b0;
	endtask : setup
	task automatic run_bit(input int a, input logic exp);
		rdr(apg_pkg::A_ST_RUN);
		chk("run bit", {31'h0, rd[a]}, {31'h0, exp});
	endtask : run_bit
	task automatic idle(input int a, input int lim);
		int n;
		n = 0;
		rdr(apg_pkg::A_ST_RUN);
		while (rd[a] !== 1'b0)
		begin
			repeat (20) @(posedge clock_in);
			rdr(apg_pkg::A_ST_RUN);
			n++;
			if (n > lim)
			begin
				chk("run end", 32'h1, 32'h0);
				end_sim();
			end
		end
	endtask : idle
	initial
	begin
		repeat (100000) @(posedge clock_in);
		chk("run time", 32'h1, 32'h0);
		end_sim();
	end
	initial
	begin
		seed = 51;
		num_errors = 0;
		check_count = 0;
		rstn_in = 1'b0;
		hsel = 1'b1;
		hsize = 3'b010;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		jumper = 1'b0;
		stop_req = 4'h0;
		clr = 1'b0;
		repeat (10) @(posedge clock_in);
		rstn_in <= 1'b1;
		@(posedge clock_in);
		for (ax = 0; ax < 4; ax++)
		begin
			wr(apg_pkg::A_AXSEL, 32'(ax << 4 | 1 << ax));
			rdr(apg_pkg::A_OFS);
			chk("offset", rd, 32'h8);
			rdr(apg_pkg::A_PROF);
			chk("profile", rd, 32'h0);
			pc = $random(seed);
			wr(apg_pkg::A_OUT, pc);
			@(negedge clock_in);
			chk("gp", {24'h0, gp}, pc & 32'hFF);
			@(posedge clock_in);
			wr(apg_pkg::A_INTP, pc);
			rdr(apg_pkg::A_INTP);
			chk("interp", rd, pc & 32'hFFFF);
		end
		wr(8'h3C, 32'hFFFFFFFF);
		rdr(8'h3C);
		chk("unmapped", rd, 32'h0);
		jumper <= 1'b1;
		repeat (4) @(posedge clock_in);
		rdr(apg_pkg::A_ST_IN);
		chk("jumper", {31'h0, rd[16]}, 32'h1);
		jumper <= 1'b0;
		wr(apg_pkg::A_PROF, 32'h2);
		wr(apg_pkg::A_DATA, 32'h1234);
		cmd(apg_pkg::C_SET_DEC, 3);
		rdr(apg_pkg::A_DEC);
		chk("decel rate", rd, 32'h1234);
		wr(apg_pkg::A_PROF, 32'h0);
		for (k = 0; k < 2; k++)
		begin
			ax = {$random(seed)} % 4;
			pc = 3 + {$random(seed)} % 6;
			setup(ax, 32'h8000, 32'h4000, pc);
			cmd(apg_pkg::C_FIX_P, ax);
			rdr(apg_pkg::A_ST_SPD);
			chk("const speed", rd, 32'h8000);
			idle(ax, 300);
			chk("pulses", {16'h0, cnt_a[ax]}, pc);
			rdr(apg_pkg::A_ST_CNT);
			chk("emitted", rd, pc);
		end
		setup(1, 32'h8000, 32'h4000, 4);
		cmd(apg_pkg::C_FIX_P, 1);
		pc = cnt_a[1];
		wr(apg_pkg::A_PCNT, 8);
		idle(1, 400);
		chk("extended", {16'h0, cnt_a[1]}, stop_at(pc, 8));
		setup(2, 32'h8000, 32'h4000, 200);
		cmd(apg_pkg::C_FIX_P, 2);
		for (k = 0; k < 5000 && cnt_a[2] < 5; k++)
			@(posedge clock_in);
		pc = cnt_a[2];
		wr(apg_pkg::A_PCNT, 2);
		repeat (4) @(posedge clock_in);
		run_bit(2, 1'b0);
		chk("shrunk", {16'h0, cnt_a[2]}, stop_at(pc, 2));
		wr(apg_pkg::A_MODE2, 32'h3);
		setup(3, 32'h8000, 32'h4000, 0);
		cmd(apg_pkg::C_CON_N, 3);
		repeat (3000) @(posedge clock_in);
		run_bit(3, 1'b1);
		chk("cw idle", {16'h0, cnt_a[3]}, 32'h0);
		chk("ccw pulses", {31'h0, cnt_b[3] > 16'h2}, 32'h1);
		cmd(apg_pkg::C_SSTOP, 3);
		repeat (4) @(posedge clock_in);
		run_bit(3, 1'b0);
		wr(apg_pkg::A_MODE2, 32'h0);
		setup(0, 32'h8000, 32'h4000, 0);
		wr(apg_pkg::A_MODE1, 32'h111);
		cmd(apg_pkg::C_CON_P, 0);
		repeat (1000) @(posedge clock_in);
		run_bit(0, 1'b1);
		stop_req <= 4'h1;
		repeat (8) @(posedge clock_in);
		run_bit(0, 1'b0);
		stop_req <= 4'h0;
		wr(apg_pkg::A_MODE1, 32'h0);
		setup(0, 32'h4000, 32'hC000, 0);
		cmd(apg_pkg::C_CON_P, 0);
		repeat (10000) @(posedge clock_in);
		rdr(apg_pkg::A_ST_SPD);
		chk("top speed", rd, 32'hC000);
		cmd(apg_pkg::C_DSTOP, 0);
		rdr(apg_pkg::A_ST_AX);
		chk("decel state", {30'h0, rd[1:0]}, 32'h3);
		idle(0, 600);
		// fixed ramp, minus direction, inverted pulse line
		wr(apg_pkg::A_MODE2, 32'h4);
		setup(0, 32'h4000, 32'hC000, 32'h14);
		cmd(apg_pkg::C_FIX_N, 0);
		idle(0, 1200);
		chk("ramp pulses", {16'h0, cnt_a[0]}, 32'h14);
		chk("dir level", {16'h0, cnt_b[0]}, 32'h1);
		rdr(apg_pkg::A_ST_SPD);
		chk("end speed", rd, 32'h4000);
		end_sim();
	end
endmodule : tb
`default_nettype wire
